// >>> core/icrc_pkg.sv
package icrc_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_TX_ABORT_CLEAR       = 8'h54;
    localparam logic [7:0] OFS_RECEIVE_FINISHED_CLR = 8'h58;
    localparam logic [7:0] OFS_ACTIVITY_CLEAR       = 8'h5C;
    localparam logic [7:0] OFS_BUS_STOP_CLEAR       = 8'h60;
    localparam logic [7:0] OFS_BUS_START_CLEAR      = 8'h64;
    localparam logic [7:0] OFS_BROADCAST_CALL_CLEAR = 8'h68;
    localparam logic [7:0] OFS_IRQ_STATUS           = 8'h80;
    localparam logic [7:0] OFS_IRQ_MASK             = 8'h84;
    localparam logic [7:0] OFS_ABORT_CAUSE          = 8'h88;
    localparam logic [7:0] OFS_RAW_STATUS           = 8'h8C;

    // ------------------------------------------------------------------
    // Flag layout
    // ------------------------------------------------------------------
    localparam int          NUM_FLAGS     = 6;
    localparam int          RAW_LSB       = 6;
    localparam int          IDX_ABORT     = 0;
    localparam int          IDX_RX_DONE   = 1;
    localparam int          IDX_ACTIVITY  = 2;
    localparam int          IDX_STOP      = 3;
    localparam int          IDX_START     = 4;
    localparam int          IDX_BROADCAST_ADDRESS_FLAG  = 5;
    localparam int          CAUSE_KEEP_BIT = 9;

    // Clear-register offsets in flag order.
    localparam logic [NUM_FLAGS-1:0][7:0] CLR_OFFS = {
        OFS_BROADCAST_CALL_CLEAR, OFS_BUS_START_CLEAR, OFS_BUS_STOP_CLEAR,
        OFS_ACTIVITY_CLEAR, OFS_RECEIVE_FINISHED_CLR, OFS_TX_ABORT_CLEAR};

    // ------------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------------
    localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 6'h00;
    localparam logic [NUM_FLAGS-1:0] MASK_RESET  = 6'h00;
    localparam logic [31:0]          CAUSE_RESET = 32'h00000000;
    localparam logic [1:0]           RESP_OKAY   = 2'h0;
    localparam logic [1:0]           RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        ICRC_RD_IDLE = 1'b0,
        ICRC_RD_RESP = 1'b1
    } icrc_rd_state_t;

endpackage

// >>> core/icrc_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RQ1 - Abort clear read wipes abort flag and cause
// RQ2 - Abort clear read releases flushed transmit FIFO
// RQ3 - Cause bit 9 survives that read wipe
// RQ4 - Finished clear read wipes receive-finished flag
// RQ5 - Activity clear read wipes flag only when idle
// RQ6 - Activity flag stays set while bus busy
// RQ7 - Activity flag self-clears when disabled and idle
// RQ8 - Activity clear bit 0 returns activity flag
// RQ9 - Stop clear read wipes stop-seen flag
// RQ10 - Start clear read wipes start-seen flag
// RQ11 - Broadcast clear read wipes broadcast flag
// RQ12 - Writes ignored; bits 31:1 read zero
module icrc_regs
    import icrc_pkg::*;
(
    input  wire logic        sys_clk,             // System clock, 40 MHz.
    input  wire logic        srst,                // Synchronous reset.
    input  wire logic [7:0]  s_axi_awaddr,        // Write address.
    input  wire logic        s_axi_awvalid,       // Write address valid.
    output logic             s_axi_awready,       // Write address ready.
    input  wire logic [31:0] s_axi_wdata,         // Write data.
    input  wire logic [3:0]  s_axi_wstrb,         // Write byte strobes.
    input  wire logic        s_axi_wvalid,        // Write data valid.
    output logic             s_axi_wready,        // Write data ready.
    output logic [1:0]       s_axi_bresp,         // Write response.
    output logic             s_axi_bvalid,        // Write response valid.
    input  wire logic        s_axi_bready,        // Write response ready.
    input  wire logic [7:0]  s_axi_araddr,        // Read address.
    input  wire logic        s_axi_arvalid,       // Read address valid.
    output logic             s_axi_arready,       // Read address ready.
    output logic [31:0]      s_axi_rdata,         // Read data.
    output logic [1:0]       s_axi_rresp,         // Read response.
    output logic             s_axi_rvalid,        // Read data valid.
    input  wire logic        s_axi_rready,        // Read data ready.
    input  wire logic        abort_evt,           // Transmit abort pulse.
    input  wire logic [31:0] abort_cause_in,      // Abort cause bits.
    input  wire logic        cause_b9_release,    // Clears cause bit 9.
    input  wire logic        rx_done_evt,         // Receive finished pulse.
    input  wire logic        bus_active,          // Controller on the bus.
    input  wire logic        ctrl_enable,         // Controller enabled.
    input  wire logic        stop_evt,            // Stop seen pulse.
    input  wire logic        start_evt,           // Start seen pulse.
    input  wire logic        broadcast_address_flag_evt,        // Broadcast address pulse.
    output logic [11:6]      unmasked_irq_status, // Raw flags, bits 11:6.
    output logic [31:0]      abort_cause_register,// Abort cause record.
    output logic             tx_fifo_flush,       // Transmit FIFO held.
    output logic             irq                  // Interrupt level.
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [NUM_FLAGS-1:0] flag_reg;
    logic [NUM_FLAGS-1:0] flag_next;
    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flag_clr;
    logic [NUM_FLAGS-1:0] rd_clr;
    logic [NUM_FLAGS-1:0] irq_stat_reg;
    logic [NUM_FLAGS-1:0] irq_mask_reg;
    logic [31:0]          cause_reg;
    logic                 flush_reg;
    logic                 aw_full_reg;
    logic                 w_full_reg;
    logic [7:0]           aw_addr_reg;
    logic [31:0]          w_data_reg;
    logic [3:0]           w_strb_reg;
    logic                 bvalid_reg;
    logic [1:0]           bresp_reg;
    logic [31:0]          rdata_reg;
    logic [1:0]           rresp_reg;
    icrc_rd_state_t       rd_state_reg;
    logic                 ar_take;
    logic                 wr_do;
    logic                 wr_stat;
    logic                 wr_mask;
    logic                 wr_known;
    logic                 abort_clr;

    // ------------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready  = !w_full_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = (rd_state_reg == ICRC_RD_IDLE);
    assign s_axi_rvalid  = (rd_state_reg == ICRC_RD_RESP);
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign wr_do   = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_stat = wr_do && (aw_addr_reg == OFS_IRQ_STATUS) && w_strb_reg[0];
    assign wr_mask = wr_do && (aw_addr_reg == OFS_IRQ_MASK) && w_strb_reg[0];

    // Clear registers accept writes silently; they only act on reads.
    always_comb begin
        wr_known = (aw_addr_reg == OFS_IRQ_STATUS) ||
                   (aw_addr_reg == OFS_IRQ_MASK) ||
                   (aw_addr_reg == OFS_ABORT_CAUSE) ||
                   (aw_addr_reg == OFS_RAW_STATUS);
        for (int k = 0; k < NUM_FLAGS; k++) begin
            if (aw_addr_reg == CLR_OFFS[k]) begin
                wr_known = 1'b1; // [RQ12]
            end
        end
    end

    // Write address and data are captured in either order.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_do) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_do) begin
            w_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read channel; a read takes effect when its address is accepted
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_state_reg <= ICRC_RD_IDLE;
            rdata_reg    <= 32'h00000000;
            rresp_reg    <= RESP_OKAY;
        end else begin
            case (rd_state_reg)
                ICRC_RD_IDLE: begin
                    if (ar_take) begin
                        rd_state_reg <= ICRC_RD_RESP;
                        rdata_reg    <= 32'h00000000; // [RQ12]
                        rresp_reg    <= RESP_OKAY;
                        case (s_axi_araddr)
                            OFS_IRQ_STATUS:
                                rdata_reg[NUM_FLAGS-1:0] <= irq_stat_reg;
                            OFS_IRQ_MASK:
                                rdata_reg[NUM_FLAGS-1:0] <= irq_mask_reg;
                            OFS_ABORT_CAUSE:
                                rdata_reg <= cause_reg;
                            OFS_RAW_STATUS:
                                rdata_reg[NUM_FLAGS-1:0] <= flag_reg;
                            default: begin
                                if (rd_clr == '0) begin
                                    rresp_reg <= RESP_SLVERR;
                                end
                                // Bit 0 shows the flag before its clear.
                                rdata_reg[0] <= |(rd_clr & flag_reg); // [RQ8]
                            end
                        endcase
                    end
                end
                ICRC_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_reg <= ICRC_RD_IDLE;
                    end
                end
                default: begin
                    rd_state_reg <= ICRC_RD_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Raw flags
    // ------------------------------------------------------------------
    assign flag_set = {broadcast_address_flag_evt, start_evt, stop_evt, bus_active,
                       rx_done_evt, abort_evt};

    generate
        for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
            assign rd_clr[i] = ar_take && (s_axi_araddr == CLR_OFFS[i]);
            if (i == IDX_ACTIVITY) begin : g_act
                // Read clears only when idle; disabled and idle self-clears.
                assign flag_clr[i] = !bus_active &&
                    (rd_clr[i] || !ctrl_enable); // [RQ5] [RQ6] [RQ7]
            end else begin : g_evt
                assign flag_clr[i] = rd_clr[i]; // [RQ1] [RQ4] [RQ9] [RQ10] [RQ11]
            end
            // A set in the cycle of a clear wins.
            assign flag_next[i] = flag_set[i] || (flag_reg[i] && !flag_clr[i]);
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flag_reg <= FLAGS_RESET;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign unmasked_irq_status = flag_reg;

    // ------------------------------------------------------------------
    // Abort cause record and transmit FIFO flush
    // ------------------------------------------------------------------
    assign abort_clr = rd_clr[IDX_ABORT];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cause_reg <= CAUSE_RESET;
        end else begin
            for (int b = 0; b < 32; b++) begin
                if (abort_evt && abort_cause_in[b]) begin
                    cause_reg[b] <= 1'b1;
                end else if (b == CAUSE_KEEP_BIT) begin
                    if (cause_b9_release) begin
                        cause_reg[b] <= 1'b0; // [RQ3]
                    end
                end else if (abort_clr) begin
                    cause_reg[b] <= 1'b0; // [RQ1]
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flush_reg <= 1'b0;
        end else if (abort_evt) begin
            flush_reg <= 1'b1;
        end else if (abort_clr) begin
            flush_reg <= 1'b0; // [RQ2]
        end
    end

    assign abort_cause_register = cause_reg;
    assign tx_fifo_flush        = flush_reg;

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_stat_reg <= FLAGS_RESET;
        end else begin
            irq_stat_reg <= (flag_next & ~flag_reg) |
                (irq_stat_reg & ~({NUM_FLAGS{wr_stat}} &
                 w_data_reg[NUM_FLAGS-1:0]));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_mask_reg <= MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_reg <= w_data_reg[NUM_FLAGS-1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    abort_clear_a: assert property ( // [RQ1]
        rd_clr[IDX_ABORT] && !abort_evt |=> !flag_reg[IDX_ABORT])
        else $error("abort flag survived its clear read");
    cause_clear_a: assert property ( // [RQ1]
        abort_clr && !abort_evt |=> cause_reg[8:0] == 9'h000 &&
        cause_reg[31:10] == 22'h000000)
        else $error("abort cause not wiped by clear read");
    fifo_release_a: assert property ( // [RQ2]
        abort_clr && !abort_evt |=>
        !tx_fifo_flush)
        else $error("transmit FIFO not released by clear read");
    bit9_keep_a: assert property ( // [RQ3]
        abort_clr && !abort_evt && !cause_b9_release |=>
        cause_reg[CAUSE_KEEP_BIT] == $past(cause_reg[CAUSE_KEEP_BIT]))
        else $error("cause bit 9 wiped by clear read");
    rx_clear_a: assert property ( // [RQ4]
        rd_clr[IDX_RX_DONE] && !rx_done_evt |=> !flag_reg[IDX_RX_DONE])
        else $error("receive-finished flag survived its clear read");
    act_idle_clr_a: assert property ( // [RQ5]
        rd_clr[IDX_ACTIVITY] && !bus_active |=> !flag_reg[IDX_ACTIVITY])
        else $error("activity flag kept while idle");
    act_busy_keep_a: assert property ( // [RQ6]
        rd_clr[IDX_ACTIVITY] && bus_active |=> flag_reg[IDX_ACTIVITY])
        else $error("activity flag cleared while busy");
    act_auto_clr_a: assert property ( // [RQ7]
        !ctrl_enable && !bus_active |=> !flag_reg[IDX_ACTIVITY])
        else $error("activity flag did not self-clear");
    act_read_val_a: assert property ( // [RQ8]
        rd_clr[IDX_ACTIVITY] |=> s_axi_rvalid &&
        s_axi_rdata[0] == $past(flag_reg[IDX_ACTIVITY]))
        else $error("activity clear read returned wrong bit");
    stop_clear_a: assert property ( // [RQ9]
        rd_clr[IDX_STOP] && !stop_evt |=> !flag_reg[IDX_STOP])
        else $error("stop flag survived its clear read");
    start_clear_a: assert property ( // [RQ10]
        rd_clr[IDX_START] && !start_evt |=> !flag_reg[IDX_START])
        else $error("start flag survived its clear read");
    gcall_clear_a: assert property ( // [RQ11]
        rd_clr[IDX_BROADCAST_ADDRESS_FLAG] && !broadcast_address_flag_evt |=> !flag_reg[IDX_BROADCAST_ADDRESS_FLAG])
        else $error("broadcast flag survived its clear read");
    write_ignored_a: assert property ( // [RQ12]
        wr_do && !ar_take |=> ((~flag_reg & $past(flag_reg)) &
        ~(6'h01 << IDX_ACTIVITY)) == 6'h00)
        else $error("a write cleared a raw flag");
    upper_zero_a: assert property ( // [RQ12]
        ar_take && rd_clr != '0 |=> s_axi_rdata[31:1] == 31'h00000000)
        else $error("clear register upper bits not zero");

    abort_cycle_c: cover property (abort_evt ##[1:20] abort_clr);
    act_busy_c:    cover property (rd_clr[IDX_ACTIVITY] && bus_active);
    irq_raise_c:   cover property (!irq ##1 irq);
    wr_then_rd_c:  cover property (wr_do ##[1:10] ar_take);

endmodule

`default_nettype wire

// >>> dv/i2c_irq_read_clear_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_irq_read_clear_regs_tb_top;
    import icrc_pkg::*;

    localparam int CEILING = 5000;

    logic        sys_clk = 1'b0;
    logic        srst    = 1'b1;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, abort_cause_in;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, abort_cause_register;
    logic        abort_evt, cause_b9_release, rx_done_evt, bus_active;
    logic        ctrl_enable, stop_evt, start_evt, broadcast_address_flag_evt;
    logic [11:6] unmasked_irq_status;
    logic        tx_fifo_flush, irq;
    int          n_mismatch  = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    always #12.5 sys_clk = ~sys_clk;

    icrc_regs dut (
        .sys_clk(sys_clk), .srst(srst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .abort_evt(abort_evt),
        .abort_cause_in(abort_cause_in), .cause_b9_release(cause_b9_release),
        .rx_done_evt(rx_done_evt), .bus_active(bus_active),
        .ctrl_enable(ctrl_enable), .stop_evt(stop_evt),
        .start_evt(start_evt), .broadcast_address_flag_evt(broadcast_address_flag_evt),
        .unmasked_irq_status(unmasked_irq_status),
        .abort_cause_register(abort_cause_register),
        .tx_fifo_flush(tx_fifo_flush), .irq(irq)
    );

    // ------------------------------------------------------------------
    // Reporting and bus tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic aw_done;
        logic w_done;
        logic b_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        b_done  = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hF;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!b_done) begin
            @(posedge sys_clk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) begin
                b_done = 1'b1;
                s_axi_bready <= 1'b0;
                chk({30'h00000000, s_axi_bresp}, {30'h00000000, er}, "bresp");
            end
        end
        @(negedge sys_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        logic ar_done;
        logic r_done;
        ar_done = 1'b0;
        r_done  = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!r_done) begin
            @(posedge sys_clk);
            if (!ar_done && s_axi_arready === 1'b1) begin
                ar_done = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) begin
                r_done = 1'b1;
                s_axi_rready <= 1'b0;
                chk(s_axi_rdata, ed, "rdata");
                chk({30'h00000000, s_axi_rresp}, {30'h00000000, er}, "rresp");
            end
        end
        @(negedge sys_clk);
    endtask

    task automatic fire(input int i);
        @(posedge sys_clk);
        case (i)
            IDX_ABORT:    abort_evt    <= 1'b1;
            IDX_RX_DONE:  rx_done_evt  <= 1'b1;
            IDX_STOP:     stop_evt     <= 1'b1;
            IDX_START:    start_evt    <= 1'b1;
            IDX_BROADCAST_ADDRESS_FLAG: broadcast_address_flag_evt <= 1'b1;
            default:      bus_active   <= 1'b1;
        endcase
        @(posedge sys_clk);
        abort_evt    <= 1'b0;
        rx_done_evt  <= 1'b0;
        stop_evt     <= 1'b0;
        start_evt    <= 1'b0;
        broadcast_address_flag_evt <= 1'b0;
        bus_active   <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic raw_chk(input logic [5:0] e);
        chk({26'h0000000, unmasked_irq_status}, {26'h0000000, e}, "raw");
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == CEILING) begin
            n_mismatch++;
            $display("BAD %0t timeout", $time);
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        {abort_evt, cause_b9_release, rx_done_evt, bus_active} = '0;
        {stop_evt, start_evt, broadcast_address_flag_evt} = '0;
        abort_cause_in = 32'h00000000;
        ctrl_enable = 1'b1;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        @(negedge sys_clk);
        raw_chk(6'h00);
        chk({31'h00000000, tx_fifo_flush}, 32'h00000000, "flush rst");
        for (int i = 0; i < NUM_FLAGS; i++) begin
            rd_chk(CLR_OFFS[i], 32'h00000000, RESP_OKAY);
        end
        // Each event flag is cleared by a read of its own clear register.
        for (int i = 0; i < NUM_FLAGS; i++) begin
            if (i != IDX_ACTIVITY) begin
                fire(i);
                raw_chk(6'(1 << i));
                rd_chk(CLR_OFFS[i], 32'h00000001, RESP_OKAY);
                raw_chk(6'h00);
                rd_chk(CLR_OFFS[i], 32'h00000001 >> 1, RESP_OKAY);
            end
        end
        // Abort clear keeps cause bit 9 and releases the FIFO.
        @(posedge sys_clk);
        abort_cause_in <= 32'h00000A05;
        fire(IDX_ABORT);
        chk(abort_cause_register, 32'h00000A05, "cause set");
        wr_chk(OFS_ABORT_CAUSE, 32'h00000000, RESP_OKAY);
        rd_chk(OFS_ABORT_CAUSE, 32'h00000A05, RESP_OKAY);
        chk({31'h00000000, tx_fifo_flush}, 32'h00000001, "flush set");
        rd_chk(OFS_TX_ABORT_CLEAR, 32'h00000001, RESP_OKAY);
        chk(abort_cause_register, 32'h00000200, "cause kept");
        chk({31'h00000000, tx_fifo_flush}, 32'h00000000, "flush");
        @(posedge sys_clk);
        cause_b9_release <= 1'b1;
        @(posedge sys_clk);
        cause_b9_release <= 1'b0;
        @(negedge sys_clk);
        chk(abort_cause_register, 32'h00000000, "cause rel");
        // Activity clears by read only when idle.
        @(posedge sys_clk);
        bus_active <= 1'b1;
        rd_chk(OFS_ACTIVITY_CLEAR, 32'h00000001, RESP_OKAY);
        raw_chk(6'h04);
        @(posedge sys_clk);
        bus_active <= 1'b0;
        @(negedge sys_clk);
        raw_chk(6'h04);
        rd_chk(OFS_ACTIVITY_CLEAR, 32'h00000001, RESP_OKAY);
        raw_chk(6'h00);
        rd_chk(OFS_ACTIVITY_CLEAR, 32'h00000000, RESP_OKAY);
        fire(IDX_ACTIVITY);
        @(posedge sys_clk);
        ctrl_enable <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        raw_chk(6'h00);
        @(posedge sys_clk);
        ctrl_enable <= 1'b1;
        // Writes leave flags alone; stray addresses are refused.
        fire(IDX_RX_DONE);
        fire(IDX_BROADCAST_ADDRESS_FLAG);
        for (int i = 0; i < NUM_FLAGS; i++) begin
            wr_chk(CLR_OFFS[i], 32'hFFFFFFFF, RESP_OKAY);
        end
        raw_chk(6'h22);
        rd_chk(OFS_RAW_STATUS, 32'h00000022, RESP_OKAY);
        rd_chk(OFS_RECEIVE_FINISHED_CLR, 32'h00000001, RESP_OKAY);
        rd_chk(OFS_BROADCAST_CALL_CLEAR, 32'h00000001, RESP_OKAY);
        wr_chk(8'h70, 32'h0000003F, RESP_SLVERR);
        rd_chk(8'h70, 32'h00000000, RESP_SLVERR);
        rd_chk(8'h55, 32'h00000000, RESP_SLVERR);
        // Interrupt: raise, mask, unmask, clear by writing one.
        wr_chk(OFS_IRQ_STATUS, 32'h0000003F, RESP_OKAY);
        rd_chk(OFS_IRQ_STATUS, 32'h00000000, RESP_OKAY);
        wr_chk(OFS_IRQ_MASK, 32'h0000003F, RESP_OKAY);
        rd_chk(OFS_IRQ_MASK, 32'h0000003F, RESP_OKAY);
        chk({31'h00000000, irq}, 32'h00000000, "irq idle");
        fire(IDX_STOP);
        chk({31'h00000000, irq}, 32'h00000001, "irq up");
        rd_chk(OFS_IRQ_STATUS, 32'h00000008, RESP_OKAY);
        wr_chk(OFS_IRQ_MASK, 32'h00000000, RESP_OKAY);
        chk({31'h00000000, irq}, 32'h00000000, "irq masked");
        wr_chk(OFS_IRQ_MASK, 32'h0000003F, RESP_OKAY);
        chk({31'h00000000, irq}, 32'h00000001, "irq unmasked");
        wr_chk(OFS_IRQ_STATUS, 32'h00000008, RESP_OKAY);
        chk({31'h00000000, irq}, 32'h00000000, "irq cleared");
        rd_chk(OFS_BUS_STOP_CLEAR, 32'h00000001, RESP_OKAY);
        raw_chk(6'h00);
        tally_and_finish();
    end
endmodule

`default_nettype wire
